/* xer_exception_unit.sv */
`timescale 1ns/1ps
`include "xer_defines.svh"

module xer_exception_unit
(
  input  wire logic        clock,
  input  wire logic        resetn,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic [31:0]      reg_rdata,
  // exception sources
  input  wire logic        sys_reset_req,
  input  wire logic [3:0]  mc_sources,
  input  wire logic        ext_irq,
  input  wire logic        dec_irq,
  input  wire logic        instr_exc,
  input  wire logic [31:0] instr_exc_pc,
  input  wire logic [5:0]  instr_exc_info,
  input  wire logic [19:0] instr_exc_vector,
  input  wire logic        fp_exc,
  input  wire logic [31:0] fp_exc_pc,
  input  wire logic        branch_done,
  input  wire logic [31:0] branch_next_pc,
  input  wire logic [31:0] next_pc,
  input  wire logic        older_pending,
  // return from handler
  input  wire logic        return_req,
  input  wire logic        pipe_drained,
  // pipeline redirect
  output logic             redirect,
  output logic [31:0]      redirect_pc,
  output logic             return_wait,
  output logic [3:0]       taken_cause,
  // state seen by the core
  output logic             branch_trace_enable,
  output logic             instr_translation_on,
  output logic             data_translation_on,
  output logic             perf_marked_process,
  output logic             recoverable_indicator,
  output logic             byte_order_select,
  output logic             fp_precise_mode,
  output logic             checkstop
);

  ////////////////////////////////////////////////////////////////////////
  // state registers

  logic [31:0] machine_state_word;
  logic [31:0] saved_return_pc;
  logic [31:0] saved_status_word;
  logic [31:0] hardware_impl_config;
  logic        trace_pending;
  logic [31:0] trace_pc;
  logic        return_pend;

  // msb-first bit access
  function automatic logic msw_bit(input logic [31:0] w, input int pos);
    msw_bit = w[31 - pos];
  endfunction

  wire ee  = msw_bit(machine_state_word, `XER_BIT_EE);
  wire me  = msw_bit(machine_state_word, `XER_BIT_ME);
  wire fe0 = msw_bit(machine_state_word, `XER_BIT_FE0);
  wire fe1 = msw_bit(machine_state_word, `XER_BIT_FE1);
  wire handler_byte_order = msw_bit(machine_state_word, `XER_BIT_ILE);
  wire ip  = msw_bit(machine_state_word, `XER_BIT_IP);

  ////////////////////////////////////////////////////////////////////////
  // state decode to the core

  assign branch_trace_enable   = msw_bit(machine_state_word, `XER_BIT_BE);
  assign instr_translation_on  = msw_bit(machine_state_word, `XER_BIT_IR);
  assign data_translation_on   = msw_bit(machine_state_word, `XER_BIT_DR);
  assign perf_marked_process   = msw_bit(machine_state_word, `XER_BIT_PM);
  assign recoverable_indicator = msw_bit(machine_state_word, `XER_BIT_RI);
  assign byte_order_select     = msw_bit(machine_state_word, `XER_BIT_LE);
  assign fp_precise_mode       = fe0 | fe1;

  ////////////////////////////////////////////////////////////////////////
  // machine check filter

  logic mc_take;

  xer_mc_filter u_mc
  (
    .clock         (clock),
    .resetn        (resetn),
    .mc_sources    (mc_sources),
    .source_enable (hardware_impl_config[3:0]),
    .mc_enable     (me),
    .mc_take       (mc_take),
    .checkstop     (checkstop)
  );

  ////////////////////////////////////////////////////////////////////////
  // cause selection by priority

  wire         fp_take    = fp_exc & fp_precise_mode;
  wire         async_ok   = ee & ~older_pending;
  wire         instr_ok   = ~older_pending;
  xer_pkg::xer_cause_e cause;

  assign cause =
    sys_reset_req                 ? xer_pkg::XER_SYS_RESET    :
    checkstop                     ? xer_pkg::XER_NONE         :
    mc_take                       ? xer_pkg::XER_MACH_CHECK   :
    (instr_exc && instr_ok)       ? xer_pkg::XER_INSTR_EXC    :
    (fp_take && instr_ok)         ? xer_pkg::XER_FP_PROGRAM   :
    (trace_pending && instr_ok)   ? xer_pkg::XER_BRANCH_TRACE :
    (ext_irq && async_ok)         ? xer_pkg::XER_EXTERNAL     :
    (dec_irq && async_ok)         ? xer_pkg::XER_DECREMENTER  :
                                    xer_pkg::XER_NONE;

  // no entry while a return is asked for or still waiting
  wire entry_block = return_req || return_pend;
  wire take        = (cause != xer_pkg::XER_NONE) && !entry_block;

  ////////////////////////////////////////////////////////////////////////
  // per-cause return address, info and vector offset

  logic [31:0] entry_pc;
  logic [5:0]  entry_info;
  logic [19:0] entry_vec;

  always_comb
  begin
    entry_pc   = next_pc;
    entry_info = 6'h00;
    entry_vec  = 20'h00000;
    unique case (cause)
      xer_pkg::XER_SYS_RESET:    entry_vec = `XER_VEC_RESET;
      xer_pkg::XER_MACH_CHECK:   entry_vec = `XER_VEC_MCHECK;
      xer_pkg::XER_INSTR_EXC:
      begin
        entry_pc   = instr_exc_pc;
        entry_info = instr_exc_info;
        entry_vec  = instr_exc_vector;
      end
      xer_pkg::XER_FP_PROGRAM:
      begin
        entry_pc   = fp_exc_pc;
        entry_info = `XER_INFO_PROG;
        entry_vec  = `XER_VEC_PROG;
      end
      xer_pkg::XER_BRANCH_TRACE:
      begin
        entry_pc = trace_pc;
        entry_vec = `XER_VEC_TRACE;
      end
      xer_pkg::XER_EXTERNAL:     entry_vec = `XER_VEC_EXT;
      xer_pkg::XER_DECREMENTER:  entry_vec = `XER_VEC_DEC;
      default:                   entry_vec = 20'h00000;
    endcase
  end

  // info bits spread onto msb-first positions 1-4 and 14-15
  wire [31:0] info_word = {1'b0, entry_info[5:2], 5'h00, 4'h0, entry_info[1:0],
                           16'h0000} & `XER_INFO_MASK;

  wire [31:0] entry_status = (machine_state_word & `XER_SAVE_MASK) | info_word;

  // machine check entry also drops the machine check enable
  wire        mc_entry  = cause == xer_pkg::XER_MACH_CHECK;
  wire [31:0] keep_bits = (`XER_KEEP_MASK | `XER_KEEP_FLD)
                        & ~(mc_entry ? `XER_ME_MASK : 32'h00000000);

  wire [31:0] entry_msw = (machine_state_word & keep_bits)
                        | {31'h0, handler_byte_order};

  logic [31:0] vector_addr;

  xer_vector u_vec
  (
    .vector_offset (entry_vec),
    .prefix_high   (ip),
    .vector_addr   (vector_addr)
  );

  ////////////////////////////////////////////////////////////////////////
  // return sequencing

  wire  do_return = (return_req || return_pend) && pipe_drained;
  assign return_wait = return_pend;

  // a return waits here until older instructions drain
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      return_pend <= 1'b0;
    else if (do_return)
      return_pend <= 1'b0;
    else if (return_req)
      return_pend <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // branch trace capture

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      trace_pending <= 1'b0;
      trace_pc      <= 32'h00000000;
    end
    else if (branch_done && branch_trace_enable)
    begin
      trace_pending <= 1'b1;
      trace_pc      <= branch_next_pc;
    end
    else if (take && cause == xer_pkg::XER_BRANCH_TRACE)
      trace_pending <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // register writes, entry and return

  // strobe qualified by an address match
  function automatic logic reg_hit(input logic strobe, input logic [3:0] addr,
                                   input logic [3:0] target);
    reg_hit = strobe && addr == target;
  endfunction

  wire wr_msw  = reg_hit(reg_write, reg_addr, `XER_ADDR_MSW);
  wire wr_spc  = reg_hit(reg_write, reg_addr, `XER_ADDR_SRR_PC);
  wire wr_sst  = reg_hit(reg_write, reg_addr, `XER_ADDR_SRR_ST);
  wire wr_hw   = reg_hit(reg_write, reg_addr, `XER_ADDR_HWCFG);

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      machine_state_word <= `XER_MSW_RESET;
      saved_return_pc    <= 32'h00000000;
      saved_status_word  <= 32'h00000000;
    end
    else if (take)
    begin
      saved_return_pc    <= entry_pc;
      saved_status_word  <= entry_status;
      machine_state_word <= entry_msw;
    end
    else if (do_return)
      machine_state_word <= saved_status_word;
    else
    begin
      if (wr_msw)
        machine_state_word <= reg_wdata;
      if (wr_spc)
        saved_return_pc <= reg_wdata;
      if (wr_sst)
        saved_status_word <= reg_wdata;
    end
  end

  // configuration register, software writes only
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      hardware_impl_config <= `XER_HWCFG_RESET;
    else if (wr_hw)
      hardware_impl_config <= reg_wdata;
  end

  ////////////////////////////////////////////////////////////////////////
  // pipeline redirect, one-cycle pulse

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      redirect    <= 1'b0;
      redirect_pc <= 32'h00000000;
      taken_cause <= 4'h0;
    end
    else
    begin
      redirect    <= take || do_return;
      redirect_pc <= take ? vector_addr : saved_return_pc;
      taken_cause <= take ? 4'(cause) : 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register read, data one cycle later

  wire [31:0] status_word = {27'h0, return_pend, trace_pending, fp_precise_mode,
                             checkstop, mc_take};
  logic [31:0] rd_mux;

  // read select by address
  always_comb
  begin
    unique case (reg_addr)
      `XER_ADDR_MSW:    rd_mux = machine_state_word;
      `XER_ADDR_SRR_PC: rd_mux = saved_return_pc;
      `XER_ADDR_SRR_ST: rd_mux = saved_status_word;
      `XER_ADDR_HWCFG:  rd_mux = hardware_impl_config;
      `XER_ADDR_STATUS: rd_mux = status_word;
      default:          rd_mux = 32'h00000000;
    endcase
  end

  // read data, zero outside the answer cycle
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 32'h00000000;
    else
      reg_rdata <= reg_read ? rd_mux : 32'h00000000;
  end

endmodule

/* xer_defines.svh */
`ifndef XER_DEFINES_SVH
`define XER_DEFINES_SVH

// machine state word bit positions (bit 0 is the msb of the word)
`define XER_BIT_ILE  15
`define XER_BIT_EE   16
`define XER_BIT_ME   19
`define XER_BIT_FE0  20
`define XER_BIT_BE   22
`define XER_BIT_FE1  23
`define XER_BIT_IP   25
`define XER_BIT_IR   26
`define XER_BIT_DR   27
`define XER_BIT_PM   29
`define XER_BIT_RI   30
`define XER_BIT_LE   31

// saved status copy mask: msb-first bits 0, 5-9, 16-31 (full-function)
`define XER_SAVE_MASK    32'h87C0FFFF
// exception-specific field: msb-first bits 1-4, 10-15
`define XER_INFO_MASK    32'h783F0000
// bits kept through entry: reserved 0, 5-12, 14 and HANDLER_BYTE_ORDER
`define XER_KEEP_MASK    32'h87FB0000
// fields kept through entry: ME and IP
`define XER_KEEP_FLD     32'h00001040
// machine check enable, dropped on machine check entry
`define XER_ME_MASK      32'h00001000

// vector base prefixes
`define XER_BASE_LOW     12'h000
`define XER_BASE_HIGH    12'hFFF

// vector offsets per cause, and program info code
`define XER_VEC_RESET    20'h00100
`define XER_VEC_MCHECK   20'h00200
`define XER_VEC_EXT      20'h00500
`define XER_VEC_PROG     20'h00700
`define XER_VEC_DEC      20'h00900
`define XER_VEC_TRACE    20'h00D00
`define XER_INFO_PROG    6'h20

// register addresses on the plain port
`define XER_ADDR_MSW     4'h0
`define XER_ADDR_SRR_PC  4'h1
`define XER_ADDR_SRR_ST  4'h2
`define XER_ADDR_HWCFG   4'h3
`define XER_ADDR_STATUS  4'h4

// reset values
`define XER_MSW_RESET    32'h00000040
`define XER_HWCFG_RESET  32'h00000000

`endif

/* xer_pkg.sv */
package xer_pkg;

  // exception causes in priority order, highest first, except XER_BRANCH_TRACE, which ranks above XER_EXTERNAL
  typedef enum logic [3:0] {
    XER_NONE,
    XER_SYS_RESET,
    XER_MACH_CHECK,
    XER_INSTR_EXC,
    XER_FP_PROGRAM,
    XER_EXTERNAL,
    XER_DECREMENTER,
    XER_BRANCH_TRACE
  } xer_cause_e;

  typedef logic [31:0] xer_word_t;

endpackage

/* xer_mc_filter.sv */
`timescale 1ns/1ps
`include "xer_defines.svh"

// per-source machine check gating and checkstop latch
module xer_mc_filter
(
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic [3:0]  mc_sources,
  input  wire logic [3:0]  source_enable,
  input  wire logic        mc_enable,
  output logic             mc_take,
  output logic             checkstop
);

  logic mc_any;

  // individual sources gated by the configuration register
  assign mc_any  = |(mc_sources & source_enable);
  assign mc_take = mc_any & mc_enable & ~checkstop;

  // checkstop is sticky until reset
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      checkstop <= 1'b0;
    else if (mc_any && !mc_enable)
      checkstop <= 1'b1;
  end

endmodule

/* xer_vector.sv */
`timescale 1ns/1ps
`include "xer_defines.svh"

// handler address from prefix select and vector offset
module xer_vector
(
  input  wire logic [19:0] vector_offset,
  input  wire logic        prefix_high,
  output logic [31:0]      vector_addr
);

  assign vector_addr = {(prefix_high ? `XER_BASE_HIGH : `XER_BASE_LOW), vector_offset};

endmodule

/* xer_pipe_model.sv */
`timescale 1ns/1ps

// interrupt sources and drain of older instructions
module xer_pipe_model
(
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic [1:0] raise,
  input  wire logic [1:0] lag,
  input  wire logic       redirect,
  input  wire logic [3:0] taken_cause,
  input  wire logic       return_wait,
  output logic            ext_irq,
  output logic            dec_irq,
  output logic            pipe_drained
);
  logic [1:0] cnt;

  // requests held until taken, drain after lag cycles
  always_ff @(posedge clock or negedge resetn)
    if (!resetn)
    begin
      ext_irq <= 1'b0;
      dec_irq <= 1'b0;
      cnt     <= 2'h0;
    end
    else
    begin
      ext_irq <= raise[0] | ext_irq & !(redirect && taken_cause == 4'h5);
      dec_irq <= raise[1] | dec_irq & !(redirect && taken_cause == 4'h6);
      cnt     <= !return_wait ? 2'h0 : cnt + 2'(cnt != lag);
    end

  assign pipe_drained = cnt == lag;
endmodule

/* xer_exception_unit_properties.sv */
`timescale 1ns/1ps

// port checks of entry and return
module xer_exception_unit_checker
(
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic        sys_reset_req,
  input wire logic [3:0]  mc_sources,
  input wire logic        ext_irq,
  input wire logic        older_pending,
  input wire logic        pipe_drained,
  input wire logic        redirect,
  input wire logic [31:0] redirect_pc,
  input wire logic        return_wait,
  input wire logic [3:0]  taken_cause,
  input wire logic        instr_translation_on,
  input wire logic        data_translation_on,
  input wire logic        fp_precise_mode,
  input wire logic        checkstop
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  // an entry, and a return held back by the drain
  sequence s_enter;
    redirect && taken_cause != 4'h0;
  endsequence
  sequence s_drain;
    return_wait && !pipe_drained;
  endsequence

  chk_entry_xlat_off:
    assert property (s_enter |-> !instr_translation_on && !data_translation_on)
    else $error("translation left on after entry");
  chk_stop_sticky:
    assert property (checkstop |=> checkstop) else $error("checkstop dropped");
  chk_drain_hold:
    assert property (s_drain |=> !redirect) else $error("return before drain");
  chk_fp_precise:
    assert property (redirect && taken_cause == 4'h4 |-> $past(fp_precise_mode))
    else $error("fp exception taken while ignored");
  chk_ext_enabled:
    assert property (redirect && taken_cause == 4'h5 |-> $past(ext_irq) && !$past(older_pending))
    else $error("external taken without cause");
  chk_mc_source:
    assert property (redirect && taken_cause == 4'h2 |-> $past(mc_sources) != 4'h0)
    else $error("machine check without source");
  chk_reset_vector:
    assert property (redirect && taken_cause == 4'h1 |->
      redirect_pc[19:0] == 20'h00100 && $past(sys_reset_req))
    else $error("bad system reset entry");
  chk_read_idle:
    assert property (!$past(reg_read) |-> reg_rdata == 32'h0) else $error("stray read data");
endmodule

bind xer_exception_unit xer_exception_unit_checker xer_exception_unit_checker_i (.clock,
  .resetn, .reg_read, .reg_rdata, .sys_reset_req, .mc_sources, .ext_irq, .older_pending,
  .pipe_drained, .redirect, .redirect_pc, .return_wait, .taken_cause, .instr_translation_on,
  .data_translation_on, .fp_precise_mode, .checkstop);

/* test_exception_entry_and_return.sv */
`timescale 1ns/1ps
`include "xer_defines.svh"

module test_exception_entry_and_return;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic        reg_write = 1'b0, reg_read = 1'b0, sys_reset_req = 1'b0;
  logic        instr_exc = 1'b0, fp_exc = 1'b0, branch_done = 1'b0;
  logic        older_pending = 1'b0, return_req = 1'b0;
  logic [3:0]  reg_addr = 4'h0, mc_sources = 4'h0, taken_cause;
  logic [31:0] reg_wdata = 32'h0, instr_exc_pc = 32'h0, fp_exc_pc = 32'h0;
  logic [31:0] branch_next_pc = 32'h0, next_pc = 32'h0, reg_rdata, redirect_pc, m, v;
  logic [5:0]  instr_exc_info = 6'h0;
  logic [19:0] instr_exc_vector = 20'h0;
  logic [1:0]  raise = 2'h0, lag = 2'h0;
  logic        ext_irq, dec_irq, pipe_drained, redirect, return_wait, checkstop;
  logic        branch_trace_enable, instr_translation_on, data_translation_on;
  logic        perf_marked_process, recoverable_indicator, byte_order_select, fp_precise_mode;
  int          fails, compares, cycles, seed = 32'h8C55D729;

  xer_exception_unit xer_exception_unit_i (.clock, .resetn, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .sys_reset_req, .mc_sources, .ext_irq, .dec_irq, .instr_exc,
    .instr_exc_pc, .instr_exc_info, .instr_exc_vector, .fp_exc, .fp_exc_pc, .branch_done,
    .branch_next_pc, .next_pc, .older_pending, .return_req, .pipe_drained, .redirect,
    .redirect_pc, .return_wait, .taken_cause, .branch_trace_enable, .instr_translation_on,
    .data_translation_on, .perf_marked_process, .recoverable_indicator, .byte_order_select,
    .fp_precise_mode, .checkstop);
  xer_pipe_model xer_pipe_model_i (.clock, .resetn, .raise, .lag, .redirect, .taken_cause,
    .return_wait, .ext_irq, .dec_irq, .pipe_drained);

  // handler address and state word after entry
  function logic [31:0] vec(input logic [31:0] w, input logic [19:0] off);
    return {w[6] ? 12'hFFF : 12'h000, off};
  endfunction
  function logic [31:0] ent(input logic [31:0] w);
    return w & 32'h87FB1040 | {31'h0, w[16]};
  endfunction

  task finish_test;
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("Error at %0t got %h expected %h", $time, g, e);
    end
  endtask

  // register port write and checked read
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task rc(input logic [3:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask

  // no redirect for n cycles
  task quiet(input int n);
    repeat (n)
    begin
      @(posedge clock);
      #1 chk(redirect, 1'b0);
    end
  endtask

  // bounded wait for redirect, then cause and target
  task tk(input logic [3:0] c, input logic [31:0] pc);
    int n;
    n = 0;
    #1;
    while (redirect !== 1'b1 && n < 20)
    begin
      @(posedge clock);
      #1 n++;
    end
    chk({redirect, taken_cause}, {1'b1, c});
    chk(redirect_pc, pc);
  endtask

  task mcp;
    mc_sources <= 4'h1;
    @(posedge clock) mc_sources <= 4'h0;
  endtask

  always #5 clock = ~clock;

  // hang guard
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      finish_test;
    end
  end

  initial
  begin
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    rc(`XER_ADDR_MSW, `XER_MSW_RESET);
    rc(`XER_ADDR_HWCFG, `XER_HWCFG_RESET);
    rc(4'h5, 32'h0);
    repeat (8)
    begin
      m = $random(seed) & 32'h00019B7F;
      wr(4'h0, m);
      #1 chk({branch_trace_enable, instr_translation_on, data_translation_on}, {m[9], m[5:4]});
      chk({perf_marked_process, recoverable_indicator, byte_order_select}, m[2:0]);
      chk(fp_precise_mode, m[11] | m[8]);
    end
    for (int d = 0; d < 2; d++)
    begin
      m = $random(seed) & 32'hFFFF1B7F;
      next_pc <= $random(seed);
      wr(4'h0, m);
      raise[d] <= 1'b1;
      @(posedge clock) raise <= 2'h0;
      quiet(5);
      m = m | 32'h00008000;
      wr(4'h0, m);
      tk(d ? 4'h6 : 4'h5, vec(m, d ? 20'h00900 : 20'h00500));
      rc(4'h1, next_pc);
      rc(4'h0, ent(m));
      rc(4'h2, m & 32'h87C0FFFF);
    end
    for (int i = 0; i < 4; i++)
    begin
      fp_exc_pc <= $random(seed);
      wr(4'h0, {20'h0, i[1], 2'h0, i[0], 8'h0});
      fp_exc <= 1'b1;
      @(posedge clock) fp_exc <= 1'b0;
      if (i == 0)
        quiet(4);
      else
      begin
        tk(4'h4, 32'h00000700);
        rc(4'h1, fp_exc_pc);
        rc(4'h2, {1'b0, 1'b1, 18'h0, i[1], 2'h0, i[0], 8'h0});
      end
    end
    m = $random(seed) & 32'h00011B7F;
    v = $random(seed);
    wr(4'h0, m);
    instr_exc_pc <= $random(seed);
    instr_exc_info <= v[5:0];
    instr_exc_vector <= v[25:6];
    older_pending <= 1'b1;
    instr_exc <= 1'b1;
    quiet(4);
    older_pending <= 1'b0;
    @(posedge clock) instr_exc <= 1'b0;
    tk(4'h3, vec(m, v[25:6]));
    rc(4'h2, m & 32'h0000FFFF | {1'b0, v[5:2], 9'h0, v[1:0], 16'h0});
    wr(4'h0, 32'h00000200);
    branch_next_pc <= $random(seed);
    branch_done <= 1'b1;
    @(posedge clock) branch_done <= 1'b0;
    tk(4'h7, 32'h00000D00);
    rc(4'h1, branch_next_pc);
    older_pending <= 1'b1;
    sys_reset_req <= 1'b1;
    @(posedge clock) sys_reset_req <= 1'b0;
    tk(4'h1, 32'h00000100);
    older_pending <= 1'b0;
    m = $random(seed) & 32'h00001B7F;
    v = $random(seed);
    wr(4'h1, v);
    wr(4'h2, m);
    lag <= 2'h3;
    return_req <= 1'b1;
    @(posedge clock) return_req <= 1'b0;
    #1 chk(return_wait, 1'b1);
    tk(4'h0, v);
    rc(4'h0, m);
    lag <= 2'h0;
    wr(4'h3, 32'h00000001);
    wr(4'h0, 32'h00001000);
    mcp;
    tk(4'h2, 32'h00000200);
    rc(4'h0, 32'h00000000);
    wr(4'h3, 32'h0000000E);
    mcp;
    quiet(4);
    wr(4'h0, 32'h0);
    wr(4'h3, 32'h00000001);
    mcp;
    quiet(4);
    chk(checkstop, 1'b1);
    rc(4'h4, 32'h00000002);
    finish_test;
  end
endmodule
